// ### hw/btps_top.sv
// Board thermal and power supervisor with AXI4-Lite registers
// Assumes all pin inputs synchronous to aclk; button input active low
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// (RULE1) Backup fan on above user threshold
// (RULE2) Overheat logic runs without processor
// (RULE3) Alarm works only when enabled
// (RULE4) Alarm asserts above alarm temperature
// (RULE5) Alarm drives overheat fan and LED
// (RULE6) Alarm outputs latched until restart
// (RULE7) CPU fan on while power on; code stops it in soft-off, where power_on stays high
// (RULE8) CPU fan may stop in sleep
// (RULE9) Intrusion latched, reported at power-on
// (RULE10) Power LED blinks slowly in suspend
// (RULE11) Key press wakes, LED steady
// (RULE12) Button press while running enters soft-off
// (RULE13) Button press in soft-off wakes
// (RULE14) Four-second hold removes all power
// (RULE15) RTC alarm wakes at programmed time
// (RULE16) Modem ring wakes from soft-off
// (RULE17) Tach measured on three headers only
// (RULE18) Button debounced; long hold only powers off
module btps_top
  import btps_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES  = HOLD_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_CYC,
  parameter int unsigned TACH_CYCLES  = TACH_CYC,
  parameter int unsigned RTC_CYCLES   = CLK_HZ
)
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [TEMP_W-1:0]   cpu_temp,
  input  wire logic                cpu_sleep,
  input  wire logic                cpu_suspend,
  input  wire logic                key_press,
  input  wire logic                pwr_btn_n,
  input  wire logic                modem_ring,
  input  wire logic                intrusion_sw,
  input  wire logic [NUM_TACH-1:0] fan_tach,
  output logic                     backup_fan,
  output logic                     overheat_fan,
  output logic                     overheat_led,
  output logic                     cpu_fan,
  output logic                     power_led,
  output logic                     power_on,
  output logic                     soft_off_state,
  output logic                     wake_cpu
);
  localparam logic [31:0] HOLD_MAX  = 32'(HOLD_CYCLES - 1);
  localparam logic [31:0] BLINK_MAX = 32'(BLINK_CYCLES - 1);
  localparam logic [31:0] TACH_MAX  = 32'(TACH_CYCLES - 1);
  localparam logic [31:0] RTC_MAX   = 32'(RTC_CYCLES - 1);
  localparam logic [15:0] DEB_MAX   = 16'(DEB_CYC - 1);

  logic [CTRL_W-1:0]  ctrl_r;
  logic [TEMP_W-1:0]  fan_thr_r;
  logic [TEMP_W-1:0]  alarm_thr_r;
  logic [TIME_W-1:0]  wake_time_r;
  logic [TIME_W-1:0]  rtc_r;
  logic [31:0]        rtc_div_r;
  logic               alarm_r;
  logic               intrude_r;
  btps_pwr_t          pwr_r;
  logic               btn_stable_r;
  logic [15:0]        deb_cnt_r;
  logic [31:0]        hold_cnt_r;
  logic               hold_fired_r;
  logic               btn_prev_r;
  logic [31:0]        blink_cnt_r;
  logic               blink_r;
  logic [31:0]        tach_cnt_r;
  logic               tach_end;
  logic [TACH_W-1:0]  tach_val [NUM_TACH];
  logic               short_press;
  logic               rtc_hit;
  logic               ring_wake;
  logic               wake_any;
  logic               aw_ok_r;
  logic               w_ok_r;
  logic [7:0]         awaddr_r;
  logic [31:0]        wdata_r;
  logic [3:0]         wstrb_r;
  logic               wr_fire;
  logic               wr_hit;

  // Write channel capture, either order
  assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_ok_r && !s_axi_bvalid;
  assign wr_fire       = aw_ok_r && w_ok_r && !s_axi_bvalid;
  assign wr_hit        = (awaddr_r == REG_CTRL) || (awaddr_r == REG_FAN_THR)
                      || (awaddr_r == REG_ALARM_THR) || (awaddr_r == REG_WAKE_TIME)
                      || (awaddr_r == REG_STATUS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ok_r      <= 1'b0;
      w_ok_r       <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ok_r  <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ok_r  <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_ok_r      <= 1'b0;
        w_ok_r       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r      <= CTRL_RST;
      fan_thr_r   <= THR_RST;
      alarm_thr_r <= THR_RST;
      wake_time_r <= 32'h0000_0000;
    end
    else if (wr_fire)
    begin
      if (awaddr_r == REG_CTRL && wstrb_r[0])
        ctrl_r <= wdata_r[CTRL_W-1:0];
      if (awaddr_r == REG_FAN_THR && wstrb_r[0])
        fan_thr_r <= wdata_r[TEMP_W-1:0];
      if (awaddr_r == REG_ALARM_THR && wstrb_r[0])
        alarm_thr_r <= wdata_r[TEMP_W-1:0];
      if (awaddr_r == REG_WAKE_TIME)
      begin
        for (int b = 0; b < 4; b++)
          if (wstrb_r[b])
            wake_time_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
      end
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        REG_CTRL:      s_axi_rdata <= 32'(ctrl_r);
        REG_FAN_THR:   s_axi_rdata <= 32'(fan_thr_r);
        REG_ALARM_THR: s_axi_rdata <= 32'(alarm_thr_r);
        REG_WAKE_TIME: s_axi_rdata <= wake_time_r;
        REG_STATUS:    s_axi_rdata <= 32'({backup_fan, soft_off_state,
                                           pwr_r == BTPS_SUSPEND, cpu_sleep,
                                           intrude_r, alarm_r});
        REG_TEMP:      s_axi_rdata <= 32'(cpu_temp);
        REG_TACH0:     s_axi_rdata <= 32'(tach_val[0]);
        REG_TACH1:     s_axi_rdata <= 32'(tach_val[1]);
        REG_TACH2:     s_axi_rdata <= 32'(tach_val[2]);
        REG_RTC:       s_axi_rdata <= rtc_r;
        default:       s_axi_rresp <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Thermal: free-running, independent of processor state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      backup_fan <= 1'b0;
    else
      backup_fan <= (cpu_temp > fan_thr_r); // RULE1 RULE2
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      alarm_r <= 1'b0; // RULE6
    else if (ctrl_r[CTRL_ALARM_EN] && cpu_temp > alarm_thr_r) // RULE3 RULE4
      alarm_r <= 1'b1; // RULE6
  end

  assign overheat_fan = alarm_r; // RULE5
  assign overheat_led = alarm_r; // RULE5

  // Intrusion latch; cleared by writing one after reported at boot
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      intrude_r <= 1'b0;
    end
    else
    begin
      if (intrusion_sw)
        intrude_r <= 1'b1; // RULE9
      else if (wr_fire && awaddr_r == REG_STATUS && wstrb_r[0] && wdata_r[ST_INTRUDE])
        intrude_r <= 1'b0;
    end
  end

  // Button debounce
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      btn_stable_r <= 1'b0;
      deb_cnt_r    <= 16'h0000;
    end
    else if ((!pwr_btn_n) == btn_stable_r)
      deb_cnt_r <= 16'h0000;
    else if (deb_cnt_r == DEB_MAX)
    begin
      btn_stable_r <= !pwr_btn_n; // RULE18
      deb_cnt_r    <= 16'h0000;
    end
    else
      deb_cnt_r <= deb_cnt_r + 16'h0001;
  end

  // Hold timer and short-press detection on release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_cnt_r   <= 32'h0000_0000;
      hold_fired_r <= 1'b0;
      btn_prev_r   <= 1'b0;
    end
    else
    begin
      btn_prev_r <= btn_stable_r;
      if (!btn_stable_r)
      begin
        hold_cnt_r   <= 32'h0000_0000;
        hold_fired_r <= 1'b0;
      end
      else if (hold_cnt_r == HOLD_MAX)
        hold_fired_r <= 1'b1; // RULE14
      else
        hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
    end
  end

  assign short_press = btn_prev_r && !btn_stable_r && !hold_fired_r; // RULE18

  // Real time clock, one tick per second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rtc_div_r <= 32'h0000_0000;
      rtc_r     <= 32'h0000_0000;
    end
    else if (rtc_div_r == RTC_MAX)
    begin
      rtc_div_r <= 32'h0000_0000;
      rtc_r     <= rtc_r + 32'h0000_0001;
    end
    else
      rtc_div_r <= rtc_div_r + 32'h0000_0001;
  end

  assign rtc_hit   = ctrl_r[CTRL_RTC_WAKE] && (rtc_r == wake_time_r); // RULE15
  assign ring_wake = ctrl_r[CTRL_RING_WAKE] && modem_ring; // RULE16
  assign wake_any  = short_press || rtc_hit || ring_wake;

  // Power state machine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwr_r <= BTPS_RUN;
    else if (hold_fired_r)
      pwr_r <= BTPS_OFF; // RULE14
    else
    begin
      unique case (pwr_r)
        BTPS_RUN:
        begin
          if (short_press)
            pwr_r <= BTPS_SOFT_OFF_STATE; // RULE12
          else if (cpu_suspend)
            pwr_r <= BTPS_SUSPEND; // RULE10
        end
        BTPS_SUSPEND:
        begin
          if (key_press || !cpu_suspend)
            pwr_r <= BTPS_RUN; // RULE11
          else if (short_press)
            pwr_r <= BTPS_SOFT_OFF_STATE;
        end
        BTPS_SOFT_OFF_STATE:
        begin
          if (wake_any)
            pwr_r <= BTPS_RUN; // RULE13 RULE15 RULE16
        end
        BTPS_OFF:
        begin
          if (short_press)
            pwr_r <= BTPS_RUN;
        end
        default: pwr_r <= BTPS_RUN;
      endcase
    end
  end

  // Suspend blink
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= 1'b1;
    end
    else if (pwr_r != BTPS_SUSPEND)
    begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= 1'b1; // RULE11
    end
    else if (blink_cnt_r == BLINK_MAX)
    begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r     <= !blink_r; // RULE10
    end
    else
      blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
  end

  // Outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      power_on       <= 1'b1;
      soft_off_state <= 1'b0;
      cpu_fan        <= 1'b1;
      power_led      <= 1'b1;
      wake_cpu       <= 1'b0;
    end
    else
    begin
      power_on       <= (pwr_r != BTPS_OFF); // RULE14
      soft_off_state <= (pwr_r == BTPS_SOFT_OFF_STATE); // RULE12
      cpu_fan        <= (pwr_r == BTPS_RUN || pwr_r == BTPS_SUSPEND)
                        && !(cpu_sleep && ctrl_r[CTRL_FAN_SAVE]); // RULE7 RULE8
      power_led      <= (pwr_r == BTPS_SUSPEND) ? blink_r : (pwr_r == BTPS_RUN);
      wake_cpu       <= (pwr_r == BTPS_SUSPEND && key_press); // RULE11
    end
  end

  // Tach measurement window
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tach_cnt_r <= 32'h0000_0000;
    else if (tach_end)
      tach_cnt_r <= 32'h0000_0000;
    else
      tach_cnt_r <= tach_cnt_r + 32'h0000_0001;
  end

  assign tach_end = (tach_cnt_r == TACH_MAX);

  for (genvar i = 0; i < NUM_TACH; i++)
  begin : g_tach
    btps_tach u_tach
    (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .window_end (tach_end),
      .tach_in    (fan_tach[i]),
      .rpm_count  (tach_val[i])
    ); // RULE17
  end
endmodule
`default_nettype wire

// ### include/btps_pkg.sv
// Package for the board thermal and power supervisor
// Assumes a 250 MHz aclk and an AXI4-Lite register bus of 32-bit words
package btps_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned HOLD_SEC        = 4;
  localparam int unsigned HOLD_CYC        = HOLD_SEC * CLK_HZ;
  localparam int unsigned DEB_US          = 10;
  localparam int unsigned DEB_CYC         = (DEB_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BLINK_MS        = 500;
  localparam int unsigned BLINK_CYC       = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned TACH_MS         = 1000;
  localparam int unsigned TACH_CYC        = TACH_MS * (CLK_HZ / 1000);
  localparam int unsigned NUM_TACH        = 3;
  localparam int unsigned TEMP_W          = 8;
  localparam int unsigned TACH_W          = 16;
  localparam int unsigned TIME_W          = 32;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_FAN_THR   = 8'h04;
  localparam logic [7:0] REG_ALARM_THR = 8'h08;
  localparam logic [7:0] REG_WAKE_TIME = 8'h0c;
  localparam logic [7:0] REG_STATUS    = 8'h10;
  localparam logic [7:0] REG_TEMP      = 8'h14;
  localparam logic [7:0] REG_TACH0     = 8'h18;
  localparam logic [7:0] REG_TACH1     = 8'h1c;
  localparam logic [7:0] REG_TACH2     = 8'h20;
  localparam logic [7:0] REG_RTC       = 8'h24;

  // Control fields
  localparam int unsigned CTRL_ALARM_EN   = 0;
  localparam int unsigned CTRL_FAN_SAVE   = 1;
  localparam int unsigned CTRL_RTC_WAKE   = 2;
  localparam int unsigned CTRL_RING_WAKE  = 3;
  localparam int unsigned CTRL_W          = 4;
  localparam logic [3:0]  CTRL_RST        = 4'h0;
  localparam logic [7:0]  THR_RST         = 8'hff;

  // Status fields
  localparam int unsigned ST_ALARM    = 0;
  localparam int unsigned ST_INTRUDE  = 1;
  localparam int unsigned ST_SLEEP    = 2;
  localparam int unsigned ST_SUSPEND  = 3;
  localparam int unsigned ST_SOFT_OFF_STATE  = 4;
  localparam int unsigned ST_BACKUP   = 5;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    BTPS_RUN     = 4'b0001,
    BTPS_SUSPEND = 4'b0010,
    BTPS_SOFT_OFF_STATE = 4'b0100,
    BTPS_OFF     = 4'b1000
  } btps_pwr_t;
endpackage

// ### hw/btps_tach.sv
// Tachometer pulse counter for one monitored fan header
// Assumes tach input synchronous to aclk, one pulse per edge counted
`timescale 1ns/1ps
`default_nettype none
module btps_tach
  import btps_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              window_end,
  input  wire logic              tach_in,
  output logic [TACH_W-1:0]      rpm_count
);
  logic              tach_d_r;
  logic [TACH_W-1:0] cnt_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tach_d_r  <= 1'b0;
      cnt_r     <= '0;
      rpm_count <= '0;
    end
    else
    begin
      tach_d_r <= tach_in;
      if (window_end)
      begin
        rpm_count <= cnt_r;
        cnt_r     <= '0;
      end
      else if (tach_in && !tach_d_r && cnt_r != '1)
        cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### verif/btps_top_assertions.sv
// Port-level checker for the supervisor, bound to btps_top
// Assumes one aclk domain and the synchronous active-low aresetn
`timescale 1ns/1ps
`default_nettype none
module btps_checker
  import btps_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES  = HOLD_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_CYC,
  parameter int unsigned TACH_CYCLES  = TACH_CYC,
  parameter int unsigned RTC_CYCLES   = CLK_HZ
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic cpu_sleep,
  input wire logic overheat_fan,
  input wire logic overheat_led,
  input wire logic cpu_fan,
  input wire logic power_led,
  input wire logic power_on,
  input wire logic soft_off_state,
  input wire logic wake_cpu
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_off_two;
    !power_on [*2];
  endsequence

  a_alarm_pair: assert property (overheat_fan == overheat_led)
    else $error("overheat fan and led differ");
  a_alarm_latch: assert property (overheat_fan |=> overheat_fan && overheat_led)
    else $error("overheat alarm dropped");
  a_cpu_fan_on: assert property ((power_on && !soft_off_state && !cpu_sleep) [*2] |-> cpu_fan)
    else $error("cpu fan off while running");
  a_off_quiet: assert property (s_off_two |-> !cpu_fan && !power_led && !soft_off_state)
    else $error("outputs alive after power off");
  a_soft_off_state_dark: assert property (soft_off_state [*2] |-> !power_led)
    else $error("power led lit in soft off");
  a_wake_pulse: assert property (wake_cpu |=> !wake_cpu)
    else $error("wake pulse too long");
  a_wake_led: assert property (wake_cpu |-> ##2 power_led [*3])
    else $error("power led not steady after wake");
  a_wr_resp: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
endmodule

bind btps_top btps_checker #(
  .HOLD_CYCLES  (HOLD_CYCLES),
  .BLINK_CYCLES (BLINK_CYCLES),
  .TACH_CYCLES  (TACH_CYCLES),
  .RTC_CYCLES   (RTC_CYCLES)
) i_chk (.*);
`default_nettype wire

// ### verif/btps_far_side.sv
// Board model: power button, temperature sensor and three tach fans
// Assumes the bench sets press and temp_set; button line pulled up
`timescale 1ns/1ps
`default_nettype none
module btps_far_side
  import btps_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                press,
  input  wire logic [TEMP_W-1:0]   temp_set,
  output logic                     pwr_btn_n,
  output logic [TEMP_W-1:0]        cpu_temp,
  output logic [NUM_TACH-1:0]      fan_tach
);
  logic [3:0] tach_cnt_r = 4'h0;

  always @(posedge aclk)
    tach_cnt_r <= tach_cnt_r + 4'h1;
  // Header n pulses once every 4 << n cycles
  assign fan_tach  = {tach_cnt_r == 4'h0, tach_cnt_r[2:0] == 3'h0, tach_cnt_r[1:0] == 2'h0};
  assign pwr_btn_n = ~press;
  assign cpu_temp  = temp_set;
endmodule
`default_nettype wire

// ### verif/board_thermal_power_supervisor_tb.sv
// Self-checking bench for the thermal and power supervisor
// Assumes btps_far_side as board model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module board_thermal_power_supervisor_tb
  import btps_pkg::*;
;
  logic                aclk, aresetn, press, cpu_sleep, cpu_suspend, key_press;
  logic                modem_ring, intrusion_sw, pwr_btn_n, wake_cpu;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready, backup_fan, overheat_fan;
  logic                overheat_led, cpu_fan, power_led, power_on, soft_off_state;
  logic [1:0]          s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]          s_axi_wstrb;
  logic [7:0]          s_axi_awaddr, s_axi_araddr;
  logic [TEMP_W-1:0]   temp_set, cpu_temp;
  logic [31:0]         s_axi_wdata, s_axi_rdata, rdat;
  logic [NUM_TACH-1:0] fan_tach;
  int unsigned         fail_count, n_tests, cyc, wakes, n;

  btps_top #(.HOLD_CYCLES(4000), .BLINK_CYCLES(8), .TACH_CYCLES(64), .RTC_CYCLES(16)) i_dut (.*);
  btps_far_side i_far (.*);

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc++;
    if (wake_cpu === 1'b1)
      wakes++;
    if (cyc == 60000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic push(input int len);
    press <= 1'b1;
    repeat (len) @(posedge aclk);
    press <= 1'b0;
    repeat (3000) @(posedge aclk);
  endtask

  task automatic t_regs();
    chk("power_on", power_on, 1'b1);
    chk("power_led", power_led, 1'b1);
    rd(REG_CTRL);
    chk("ctrl", rdat, 32'h0);
    rd(REG_FAN_THR);
    chk("fan thr", rdat, 32'hff);
    rd(8'h3c);
    chk("unmapped", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h3c, 32'h0);
    chk("wr unmapped", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 3; i++)
    begin
      rd(REG_TACH0 + 8'(4 * i));
      chk("tach", rdat, 32'h10 >> i);
    end
  endtask

  task automatic t_thermal();
    wr(REG_FAN_THR, 32'h50);
    chk("wr okay", {30'h0, rsp}, {30'h0, RESP_OKAY});
    wr(REG_ALARM_THR, 32'h60);
    cpu_sleep <= 1'b1;
    temp_set <= 8'h50;
    repeat (4) @(posedge aclk);
    chk("backup at thr", backup_fan, 1'b0);
    temp_set <= 8'h70;
    repeat (4) @(posedge aclk);
    chk("backup above", backup_fan, 1'b1);
    chk("alarm disabled", overheat_fan, 1'b0);
    temp_set <= 8'h60;
    wr(REG_CTRL, 32'h1);
    repeat (4) @(posedge aclk);
    chk("alarm at thr", overheat_fan, 1'b0);
    temp_set <= 8'h61;
    repeat (4) @(posedge aclk);
    chk("alarm led", overheat_led, 1'b1);
    temp_set <= 8'h20;
    repeat (4) @(posedge aclk);
    chk("alarm kept", overheat_fan, 1'b1);
    chk("cpu fan no save", cpu_fan, 1'b1);
    wr(REG_CTRL, 32'h3);
    repeat (4) @(posedge aclk);
    chk("cpu fan saved", cpu_fan, 1'b0);
    cpu_sleep <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("cpu fan on", cpu_fan, 1'b1);
  endtask

  task automatic t_suspend();
    intrusion_sw <= 1'b1;
    cpu_suspend <= 1'b1;
    repeat (4) @(posedge aclk);
    intrusion_sw <= 1'b0;
    rd(REG_STATUS);
    chk("intrusion", rdat[ST_INTRUDE], 1'b1);
    chk("status", rdat, 32'h0000_000b);
    n = 0;
    repeat (32)
    begin
      @(posedge aclk);
      n += (power_led === 1'b1);
    end
    chk("blink", n, 32'h10);
    key_press <= 1'b1;
    @(posedge aclk);
    key_press <= 1'b0;
    cpu_suspend <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("wake", wakes, 32'h1);
    chk("led steady", power_led, 1'b1);
  endtask

  task automatic t_button();
    wr(REG_CTRL, 32'hd);
    push(3000);
    chk("soft off", soft_off_state, 1'b1);
    rd(REG_RTC);
    wr(REG_WAKE_TIME, rdat + 32'h3);
    chk("rtc early", soft_off_state, 1'b1);
    repeat (100) @(posedge aclk);
    chk("rtc wake", soft_off_state, 1'b0);
    push(3000);
    chk("soft off again", soft_off_state, 1'b1);
    push(3000);
    chk("button wake", soft_off_state, 1'b0);
    push(3000);
    chk("soft off ring", soft_off_state, 1'b1);
    modem_ring <= 1'b1;
    repeat (4) @(posedge aclk);
    modem_ring <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("ring wake", soft_off_state, 1'b0);
    press <= 1'b1;
    repeat (6300) @(posedge aclk);
    chk("early off", power_on, 1'b1);
    repeat (400) @(posedge aclk);
    chk("hold off", power_on, 1'b0);
    press <= 1'b0;
    repeat (3000) @(posedge aclk);
    chk("off after hold", power_on, 1'b0);
    push(3000);
    chk("power back", power_on, 1'b1);
    rd(REG_STATUS);
    chk("intrusion kept", rdat[ST_INTRUDE], 1'b1);
    wr(REG_STATUS, 32'h2);
    rd(REG_STATUS);
    chk("intrusion clr", rdat[ST_INTRUDE], 1'b0);
  endtask

  initial
  begin
    {fail_count, n_tests, cyc, wakes} = '0;
    {aresetn, press, cpu_sleep, cpu_suspend, key_press, modem_ring, intrusion_sw} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    temp_set = 8'h20;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (200) @(posedge aclk);
    t_regs();
    t_thermal();
    t_suspend();
    t_button();
    tally_and_finish();
  end
endmodule
`default_nettype wire
